//--- inc/bpt_pkg.sv
// Package: register map, field layout, reset values and carrier types of the byte port.
`default_nettype none
package bpt_pkg;
    // ****************************************
    // Register indices and byte addresses
    // ****************************************
    localparam logic [7:0] BPT_IDX_DATA = 8'h38;
    localparam logic [7:0] BPT_IDX_XSEL = 8'h3C;
    localparam logic [7:0] BPT_IDX_FUNC = 8'h3D;
    localparam logic [7:0] BPT_IDX_DRIVE = 8'h3E;
    localparam logic [7:0] BPT_IDX_DIR = 8'h3F;
    localparam logic [7:0] BPT_ADDR_DATA = {BPT_IDX_DATA[5:0], 2'b00};
    localparam logic [7:0] BPT_ADDR_XSEL = {BPT_IDX_XSEL[5:0], 2'b00};
    localparam logic [7:0] BPT_ADDR_FUNC = {BPT_IDX_FUNC[5:0], 2'b00};
    localparam logic [7:0] BPT_ADDR_DRIVE = {BPT_IDX_DRIVE[5:0], 2'b00};
    localparam logic [7:0] BPT_ADDR_DIR = {BPT_IDX_DIR[5:0], 2'b00};

    // ****************************************
    // Field positions
    // ****************************************
    localparam int unsigned BPT_XSEL_LO_LSB = 0;
    localparam int unsigned BPT_XSEL_HI_LSB = 4;
    localparam int unsigned BPT_BIT_SCLK_SECOND = 0;
    localparam int unsigned BPT_BIT_SCLK_FIRST = 1;
    localparam int unsigned BPT_PWM_LSB = 4;
    // Pins that own an alternate output; bits 2 and 3 have none.
    localparam logic [7:0] BPT_ALT_MASK = 8'hF3;

    // ****************************************
    // Transfer clock sources
    // ****************************************
    typedef enum logic [1:0] {
        BPT_XCLK_HALF,
        BPT_XCLK_TA1,
        BPT_XCLK_TB1,
        BPT_XCLK_TB2
    } bpt_xclk_t;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] BPT_RST_DIR = 8'h00;
    localparam logic [7:0] BPT_RST_DRIVE = 8'h00;
    localparam logic [7:0] BPT_RST_FUNC = 8'h00;
    localparam logic [7:0] BPT_RST_BUF = 8'h00;
    localparam logic [7:0] BPT_RST_PINREG = 8'h00;
    localparam bpt_xclk_t BPT_RST_XSEL = BPT_XCLK_HALF;
    localparam logic [31:0] BPT_RDATA_NONE = 32'h0000_0000;

    // ****************************************
    // Carrier types
    // ****************************************
    typedef struct packed {
        logic [3:0] pwm;
        logic sclkFirst;
        logic sclkSecond;
    } bpt_alt_t;

    typedef struct packed {
        logic a1;
        logic b1;
        logic b2;
    } bpt_tstrb_t;

    typedef struct packed {
        logic q1;
        logic i1;
        logic q2;
        logic i2;
    } bpt_quad_t;
endpackage
`default_nettype wire

//--- logic/bpt_pin_sync.sv
// Two-stage synchroniser for the port pin levels.
`default_nettype none
module bpt_pin_sync #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic clock,              // System clock.
    input wire logic rst_n,              // Asynchronous reset, active low.
    input wire logic ce,                 // Clock enable; state holds while low.
    input wire logic [WIDTH-1:0] asyncIn, // Raw pin levels.
    output logic [WIDTH-1:0] syncOut     // Levels after two flip-flops.
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else if (ce)
        begin
            meta_q <= asyncIn;
            sync_q <= meta_q;
        end
    end

    assign syncOut = sync_q;
endmodule
`default_nettype wire

//--- logic/bpt_port.sv
// Eight-bit general-purpose port with timed output update, reached over APB.
`default_nettype none
module bpt_port #(
    parameter int unsigned ADDR_W = 8
) (
    input wire logic clock,                  // System clock, 100 MHz.
    input wire logic rst_n,                  // Asynchronous reset, active low.
    input wire logic ce,                     // Clock enable; all state holds while low.
    input wire logic psel,                   // APB select.
    input wire logic penable,                // APB enable.
    input wire logic pwrite,                 // APB direction, high for write.
    input wire logic [ADDR_W-1:0] paddr,     // APB byte address.
    input wire logic [31:0] pwdata,          // APB write data.
    output logic [31:0] prdata,              // APB read data, registered.
    output logic pready,                     // APB ready.
    output logic pslverr,                    // APB error on unmapped address.
    input wire logic [7:0] pinIn,            // Pin levels from the pads.
    output logic [7:0] pinOut,               // Pin output values.
    output logic [7:0] pinOe,                // Pin output enables, high drives.
    input wire bpt_pkg::bpt_alt_t altIn,     // Alternate output sources.
    input wire bpt_pkg::bpt_tstrb_t tmrStb,  // Timer strobes, one cycle each.
    input wire logic [1:0] serialIntClk,     // Bit 0 second, bit 1 first channel.
    input wire logic quadUpper,              // High takes decoder inputs from 4-7.
    output bpt_pkg::bpt_quad_t quadOut       // Decoder inputs, registered.
);
    // ****************************************
    // Register state
    // ****************************************
    logic [7:0] dir_q;
    logic [7:0] drive_q;
    logic [7:0] func_q;
    logic [7:0] buf_q;
    logic [7:0] pinReg_q;
    bpt_pkg::bpt_xclk_t xselLo_q;
    bpt_pkg::bpt_xclk_t xselHi_q;
    logic half_q;
    logic [31:0] prdata_q;
    bpt_pkg::bpt_quad_t quad_q;
    logic [7:0] pinSync;

    // ****************************************
    // Pin input synchroniser
    // ****************************************
    bpt_pin_sync #(
        .WIDTH(8)
    ) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .asyncIn(pinIn),
        .syncOut(pinSync)
    );

    // ****************************************
    // APB decode
    // ****************************************
    wire setupPh = psel & ~penable;
    wire accessPh = psel & penable;
    wire hitData = paddr == ADDR_W'(bpt_pkg::BPT_ADDR_DATA);
    wire hitXsel = paddr == ADDR_W'(bpt_pkg::BPT_ADDR_XSEL);
    wire hitFunc = paddr == ADDR_W'(bpt_pkg::BPT_ADDR_FUNC);
    wire hitDrive = paddr == ADDR_W'(bpt_pkg::BPT_ADDR_DRIVE);
    wire hitDir = paddr == ADDR_W'(bpt_pkg::BPT_ADDR_DIR);
    wire mapped = hitData | hitXsel | hitFunc | hitDrive | hitDir;
    wire wrStb = ce & accessPh & pwrite & mapped;
    wire rdCapture = ce & setupPh & ~pwrite;
    wire [31:0] rdNext = hitData ? {24'h00_0000, pinSync} : bpt_pkg::BPT_RDATA_NONE;

    // Zero wait states; a held-low clock enable stretches the access phase.
    assign pready = ce;
    assign pslverr = accessPh & ~mapped;
    assign prdata = prdata_q;

    // ****************************************
    // Transfer strobes
    // ****************************************
    function automatic logic pickStrobe(
        input bpt_pkg::bpt_xclk_t sel,
        input logic half,
        input bpt_pkg::bpt_tstrb_t t
    );
        logic s;
        s = 1'b0;
        unique case (sel)
            bpt_pkg::BPT_XCLK_HALF: s = half;
            bpt_pkg::BPT_XCLK_TA1: s = t.a1;
            bpt_pkg::BPT_XCLK_TB1: s = t.b1;
            bpt_pkg::BPT_XCLK_TB2: s = t.b2;
        endcase
        return s;
    endfunction

    wire xferLo = ce & pickStrobe(xselLo_q, half_q, tmrStb);
    wire xferHi = ce & pickStrobe(xselHi_q, half_q, tmrStb);

    // ****************************************
    // Pad drive
    // ****************************************
    wire [7:0] forceOut = {6'h00, serialIntClk[1], serialIntClk[0]};
    wire [7:0] dirEff = dir_q | forceOut;
    wire [7:0] altVec = {altIn.pwm, pinReg_q[3:2], altIn.sclkFirst, altIn.sclkSecond};
    wire [7:0] useAlt = func_q & bpt_pkg::BPT_ALT_MASK;
    wire [7:0] srcVal = (useAlt & altVec) | (~useAlt & pinReg_q);

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_pad
            assign pinOut[gi] = drive_q[gi] ? 1'b0 : srcVal[gi];
            assign pinOe[gi] = dirEff[gi] & (~drive_q[gi] | ~srcVal[gi]);
        end
    endgenerate

    // ****************************************
    // Control registers
    // ****************************************
    // Direction register and its reset.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            dir_q <= bpt_pkg::BPT_RST_DIR;
        else if (wrStb && hitDir)
            dir_q <= pwdata[7:0];
    end

    // Drive type reset is arbitrary; direction keeps pins as inputs.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            drive_q <= bpt_pkg::BPT_RST_DRIVE;
        else if (wrStb && hitDrive)
            drive_q <= pwdata[7:0];
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            func_q <= bpt_pkg::BPT_RST_FUNC;
        else if (wrStb && hitFunc)
            func_q <= pwdata[7:0];
    end

    // Only the two select fields are stored.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            xselLo_q <= bpt_pkg::BPT_RST_XSEL;
            xselHi_q <= bpt_pkg::BPT_RST_XSEL;
        end
        else if (wrStb && hitXsel)
        begin
            xselLo_q <= bpt_pkg::bpt_xclk_t'(pwdata[bpt_pkg::BPT_XSEL_LO_LSB +: 2]);
            xselHi_q <= bpt_pkg::bpt_xclk_t'(pwdata[bpt_pkg::BPT_XSEL_HI_LSB +: 2]);
        end
    end

    // ****************************************
    // Output buffer and pin register
    // ****************************************
    // Software write lands in the buffer.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            buf_q <= bpt_pkg::BPT_RST_BUF;
        else if (wrStb && hitData)
            buf_q <= pwdata[7:0];
    end

    // One copy per strobe; a write in the same cycle waits for the next strobe.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            pinReg_q <= bpt_pkg::BPT_RST_PINREG;
        else
        begin
            if (xferLo)
                pinReg_q[3:0] <= buf_q[3:0];
            if (xferHi)
                pinReg_q[7:4] <= buf_q[7:4];
        end
    end

    // Half-rate strobe: high on every other enabled cycle.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            half_q <= 1'b0;
        else if (ce)
            half_q <= ~half_q;
    end

    // ****************************************
    // Read data and decoder feed
    // ****************************************
    // Read data captured from the live pins in the setup phase.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            prdata_q <= bpt_pkg::BPT_RDATA_NONE;
        else if (rdCapture)
            prdata_q <= rdNext;
    end

    // Decoder inputs from either nibble, same bit order.
    wire [3:0] quadNib = quadUpper ? pinSync[7:4] : pinSync[3:0];

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            quad_q <= '0;
        else if (ce)
            quad_q <= '{q1: quadNib[0], i1: quadNib[1], q2: quadNib[2], i2: quadNib[3]};
    end

    assign quadOut = quad_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_dir_gates_oe: assert property ((pinOe & ~dirEff) == 8'h00)
        else $error("Pin enabled while its direction selects input.");

    a_open_drain_low: assert property ((pinOut & drive_q) == 8'h00 && (pinOe & drive_q & srcVal) == 8'h00)
        else $error("Open drain pin drove high.");

    a_pushpull_drives: assert property ((dirEff & ~drive_q) == (pinOe & ~drive_q))
        else $error("Push-pull output pin not enabled.");

    a_reset_inputs: assert property (!$past(rst_n) && serialIntClk == 2'b00 |-> pinOe == 8'h00)
        else $error("Pin driven right after reset.");

    a_data_select: assert property (((pinOut ^ pinReg_q) & dirEff & ~useAlt & ~drive_q) == 8'h00)
        else $error("Output pin does not show the pin register.");

    a_pwm_route: assert property (func_q[7:4] == 4'hF && drive_q[7:4] == 4'h0 |-> pinOut[7:4] == altIn.pwm)
        else $error("Pwm output not routed to upper pins.");

    a_lo_transfer: assert property (ce && xselLo_q == bpt_pkg::BPT_XCLK_TB2 && tmrStb.b2
        |=> pinReg_q[3:0] == $past(buf_q[3:0]))
        else $error("Lower nibble missed its timer strobe.");

    a_xsel_write: assert property (wrStb && hitXsel |=> xselHi_q == $past(pwdata[5:4]))
        else $error("Upper transfer select not stored.");

    a_read_live: assert property (rdCapture && hitData |=> prdata == {24'h00_0000, $past(pinSync)})
        else $error("Data read does not return pin levels.");

    // check half clock update
    // The select must still be the half clock when the strobe arrives, or no copy is due.
    a_half_update: assert property (ce && xselHi_q == bpt_pkg::BPT_XCLK_HALF && !half_q
        ##1 ce && xselHi_q == bpt_pkg::BPT_XCLK_HALF ##1 ce |=> pinReg_q[7:4] == $past(buf_q[7:4], 2))
        else $error("Upper nibble not copied on half clock.");

    a_serial_force: assert property (serialIntClk[1] && !drive_q[1] |-> pinOe[1])
        else $error("Serial clock pin not forced to output.");

    a_quad_lower: assert property (ce && !quadUpper |=> quadOut.i2 == $past(pinSync[3]))
        else $error("Decoder input not taken from pin 3.");

    a_hold_no_strobe: assert property (!xferLo |=> $stable(pinReg_q[3:0]))
        else $error("Lower nibble changed without a strobe.");

    a_dir_write: assert property (wrStb && hitDir |=> dir_q == $past(pwdata[7:0]))
        else $error("Direction register missed a write.");

    a_drive_write: assert property (wrStb && hitDrive |=> drive_q == $past(pwdata[7:0]))
        else $error("Drive type register missed a write.");

    a_func_write: assert property (wrStb && hitFunc |=> func_q == $past(pwdata[7:0]))
        else $error("Function register missed a write.");

    a_sclk_route: assert property (func_q[1:0] == 2'b11 && drive_q[1:0] == 2'b00
        |-> pinOut[1:0] == {altIn.sclkFirst, altIn.sclkSecond})
        else $error("Serial clocks not routed to pins 0 and 1.");

    a_hi_transfer: assert property (ce && xselHi_q == bpt_pkg::BPT_XCLK_TA1 && tmrStb.a1
        |=> pinReg_q[7:4] == $past(buf_q[7:4]))
        else $error("Upper nibble missed its timer strobe.");

    a_lo_b_transfer: assert property (ce && xselLo_q == bpt_pkg::BPT_XCLK_TB1 && tmrStb.b1
        |=> pinReg_q[3:0] == $past(buf_q[3:0]))
        else $error("Lower nibble missed its timer strobe.");

    a_lo_xsel_write: assert property (wrStb && hitXsel |=> xselLo_q == $past(pwdata[1:0]))
        else $error("Lower transfer select not stored.");

    a_read_zero: assert property (rdCapture && !hitData |=> prdata == bpt_pkg::BPT_RDATA_NONE)
        else $error("Read of a non-data address returned nonzero.");

    a_buf_write: assert property (wrStb && hitData |=> buf_q == $past(pwdata[7:0]))
        else $error("Output buffer missed a write.");

    a_quad_upper: assert property (ce && quadUpper |=> quadOut.q1 == $past(pinSync[4]))
        else $error("Decoder input not taken from pin 4.");

    a_hold_upper: assert property (!xferHi |=> $stable(pinReg_q[7:4]))
        else $error("Upper nibble changed without a strobe.");

    a_frozen_state: assert property (!ce |=> $stable(pinReg_q) && $stable(buf_q) && $stable(half_q))
        else $error("State moved while the clock enable was low.");
endmodule
`default_nettype wire

//--- testbench/bpt_ext_pads.sv
// External circuit on the eight port pins: pull-ups and an optional driver.
`default_nettype none
module bpt_ext_pads (
    input wire logic [7:0] pinOut, // Device output value.
    input wire logic [7:0] pinOe,  // Device output enable.
    input wire logic [7:0] extOe,  // External driver enable per pin.
    input wire logic [7:0] extVal, // External driver value.
    output logic [7:0] pinLevel    // Resolved wire level.
);
    timeunit 1ns;
    timeprecision 1ps;
    // A pin nobody drives sits at its pull-up; two drivers fighting give an unknown level.
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (pinOe[i] && extOe[i])
                pinLevel[i] = 1'bx;
            else if (pinOe[i])
                pinLevel[i] = pinOut[i];
            else if (extOe[i])
                pinLevel[i] = extVal[i];
            else
                pinLevel[i] = 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench for the byte port: APB traffic, pad checks and a read scoreboard.
`default_nettype none
`define CHK(name, exp, got) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
    $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] pinLevel;
    logic [7:0] pinOut;
    logic [7:0] pinOe;
    logic [7:0] extVal = 8'h00;
    logic [7:0] extOe = 8'h00;
    bpt_pkg::bpt_alt_t altIn = 6'h00;
    bpt_pkg::bpt_tstrb_t tmrStb = 3'h0;
    logic [1:0] serialIntClk = 2'h0;
    logic quadUpper = 1'b0;
    logic ce = 1'b1;
    bpt_pkg::bpt_quad_t quadOut;
    logic [32:0] expQ[$];
    logic [32:0] seen;
    int failures = 0;
    int samples_checked = 0;
    int seed = 47;
    logic [7:0] d;
    logic [7:0] e;
    logic [7:0] o;

    always #5 clock = ~clock;

    bpt_port u_bpt_port (.clock(clock), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pinIn(pinLevel), .pinOut(pinOut), .pinOe(pinOe), .altIn(altIn),
        .tmrStb(tmrStb), .serialIntClk(serialIntClk), .quadUpper(quadUpper), .quadOut(quadOut));
    bpt_ext_pads u_bpt_ext_pads (.pinOut(pinOut), .pinOe(pinOe), .extOe(extOe), .extVal(extVal),
        .pinLevel(pinLevel));

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // For a read, the expectation {pslverr, prdata} is queued at setup and taken when the access completes.
    // Only the watchdog ends a wait for ready.
    task automatic apb(input logic isWr, input logic [7:0] addr, input logic [7:0] data, input logic [32:0] exp);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= isWr;
        paddr <= addr;
        pwdata <= {24'h000000, data};
        if (!isWr)
            expQ.push_back(exp);
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
        end
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        apb(1'b1, addr, data, 33'h0_0000_0000);
    endtask

    task automatic rd(input logic [7:0] addr, input logic [32:0] exp);
        apb(1'b0, addr, 8'h00, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Pads are looked at mid-cycle, where they have settled; the task returns on a rising edge.
    task automatic chkPads(input logic [7:0] expOut, input logic [7:0] expOe);
        @(negedge clock);
        `CHK("pinOut", expOut, pinOut)
        `CHK("pinOe", expOe, pinOe)
        @(posedge clock);
    endtask

    always @(posedge clock)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0)
        begin
            seen = expQ.pop_front();
            `CHK("prdata", seen[31:0], prdata)
            `CHK("pslverr", seen[32], pslverr)
        end
    end

    initial
    begin
        #200us;
        failures++;
        end_sim();
    end

    initial
    begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        cyc(3);
        chkPads(8'h00, 8'h00);
        rd(bpt_pkg::BPT_ADDR_DATA, 33'h0_0000_00FF);
        rd(bpt_pkg::BPT_ADDR_DIR, 33'h0_0000_0000);
        rd(8'h00, 33'h1_0000_0000);
        wr(bpt_pkg::BPT_ADDR_DIR, 8'hFF);
        d = 8'($random(seed));
        wr(bpt_pkg::BPT_ADDR_DATA, d);
        cyc(4);
        chkPads(d, 8'hFF);
        rd(bpt_pkg::BPT_ADDR_DATA, {25'h0000000, d});
        wr(bpt_pkg::BPT_ADDR_DIR, 8'h00);
        e = 8'($random(seed));
        extOe <= 8'hFF;
        extVal <= e;
        wr(bpt_pkg::BPT_ADDR_DATA, ~e);
        cyc(4);
        rd(bpt_pkg::BPT_ADDR_DATA, {25'h0000000, e});
        @(negedge clock);
        `CHK("quadLower", {e[0], e[1], e[2], e[3]}, quadOut)
        @(posedge clock);
        quadUpper <= 1'b1;
        cyc(3);
        @(negedge clock);
        `CHK("quadUpper", {e[4], e[5], e[6], e[7]}, quadOut)
        wr(bpt_pkg::BPT_ADDR_DRIVE, 8'hFF);
        cyc(1);
        chkPads(8'h00, 8'h00);
        extOe <= 8'h00;
        wr(bpt_pkg::BPT_ADDR_DRIVE, 8'h0F);
        wr(bpt_pkg::BPT_ADDR_DIR, 8'hFF);
        d = 8'($random(seed));
        wr(bpt_pkg::BPT_ADDR_DATA, d);
        cyc(4);
        @(negedge clock);
        `CHK("pinLevel", d, pinLevel)
        chkPads({d[7:4], 4'h0}, {4'hF, ~d[3:0]});
        wr(bpt_pkg::BPT_ADDR_DRIVE, 8'h00);
        wr(bpt_pkg::BPT_ADDR_DIR, 8'h00);
        serialIntClk <= 2'h3;
        cyc(1);
        chkPads(d, 8'h03);
        serialIntClk <= 2'h0;
        wr(bpt_pkg::BPT_ADDR_DIR, 8'hFF);
        wr(bpt_pkg::BPT_ADDR_FUNC, 8'hFF);
        altIn <= 6'($random(seed));
        cyc(1);
        chkPads({altIn.pwm, d[3:2], altIn.sclkFirst, altIn.sclkSecond}, 8'hFF);
        wr(bpt_pkg::BPT_ADDR_FUNC, 8'h00);
        o = d;
        for (int c = 1; c < 4; c++)
        begin
            wr(bpt_pkg::BPT_ADDR_XSEL, {2'b11, c[1:0], 2'b11, c[1:0]});
            d = 8'($random(seed));
            wr(bpt_pkg::BPT_ADDR_DATA, d);
            tmrStb <= 3'(~(3'h4 >> (c - 1)));
            cyc(1);
            tmrStb <= 3'h0;
            cyc(3);
            chkPads(o, 8'hFF);
            tmrStb <= 3'(3'h4 >> (c - 1));
            cyc(1);
            tmrStb <= 3'h0;
            cyc(2);
            chkPads(d, 8'hFF);
            o = d;
        end
        // A strobe while the clock enable is low is lost.
        wr(bpt_pkg::BPT_ADDR_DATA, ~o);
        ce <= 1'b0;
        tmrStb <= 3'h1;
        cyc(1);
        tmrStb <= 3'h0;
        ce <= 1'b1;
        cyc(2);
        chkPads(o, 8'hFF);
        tmrStb <= 3'h1;
        cyc(1);
        tmrStb <= 3'h0;
        cyc(2);
        chkPads(~o, 8'hFF);
        rst_n <= 1'b0;
        cyc(2);
        chkPads(8'h00, 8'h00);
        rst_n <= 1'b1;
        wr(bpt_pkg::BPT_ADDR_DIR, 8'hFF);
        d = 8'($random(seed));
        wr(bpt_pkg::BPT_ADDR_DATA, d);
        cyc(4);
        chkPads(d, 8'hFF);
        end_sim();
    end
endmodule
`default_nettype wire
